// file: pps_pkg.sv
// shared constants and carriers for the power sequencer
package pps_pkg;
  localparam int unsigned CLK_HZ = 200_000_000;
  // long press threshold, seconds
  localparam int unsigned LONG_PRESS_S = 4;
  localparam longint unsigned LONG_PRESS_CYC = longint'(LONG_PRESS_S) * CLK_HZ;
  // reset release delay after rail twelve good, milliseconds
  localparam int unsigned RST_DELAY_MS = 40;
  localparam longint unsigned RST_DELAY_CYC = longint'(RST_DELAY_MS) * (CLK_HZ / 1000);
  localparam int unsigned NUM_MAIN = 10;
  // main group order: 7,2,4,1,5,6,8,10,11,12
  localparam int unsigned IDX_RAIL_SEVEN = 0;
  localparam int unsigned IDX_RAIL_TWO = 1;
  localparam int unsigned IDX_RAIL_TWELVE = 9;
  localparam logic [NUM_MAIN-1:0] MAIN_ALL_ON = 10'h3ff;
  localparam logic [NUM_MAIN-1:0] MAIN_ALL_OFF = 10'h000;

  typedef struct packed {
    logic wake_trigger_pin;
    logic power_hold_input;
    logic rail_three_enable_input;
    logic push_button_pressed;
    logic rail_two_voltage_select;
    logic uvlo_ok;
    logic irq_event;
  } pps_ctl_t;

  typedef enum logic [1:0] {
    PPS_OFF,
    PPS_WAKE,
    PPS_HELD,
    PPS_LONG_OFF
  } pps_state_t;
endpackage

// file: pps_sequencer.sv
// power sequencer top: rail enables, button, reset and interrupt pins
`timescale 1ns/1ps
// Overview of operation
// - keep-alive rail turns on once input is above under-voltage lockout
// - wake trigger high starts the main rail group
// - once power hold is high the group stays on regardless of wake
// - rail three enable is power hold AND rail three enable input, held off in long-press state
// - rail three drops when either of its two enables goes low
// - button held over four seconds shuts main group down
// - power hold low while wake low shuts main group down
// - short button press pulls processor reset low
// - long press powers down the main group and rail three; keep-alive stays on
// - release after long press restarts the normal startup sequence
// - reset held until rail twelve good, then released after 40 ms
// - interrupt output is open drain, only ever pulled low
// - rail two select low gives 1.0 V, high gives 1.1 V
// - press shorter than threshold is short, longer is long
module pps_sequencer
  import pps_pkg::*;
#(
  parameter longint unsigned LONG_CYC = LONG_PRESS_CYC,
  parameter longint unsigned RST_CYC = RST_DELAY_CYC
) (
  input wire logic mclk,
  input wire logic srst,
  input wire pps_ctl_t ctl,
  input wire logic [NUM_MAIN-1:0] main_power_good,
  output logic keep_alive_rail_en,
  output logic [NUM_MAIN-1:0] main_rail_en,
  output logic rail_three_en,
  output logic rail_two_vsel_high,
  output logic processor_reset_output_n,
  output logic interrupt_request_output_out,
  output logic interrupt_request_output_oe
);
  pps_state_t state;
  logic [63:0] press_cnt;
  logic [63:0] rst_cnt;
  logic long_seen;
  logic short_pulse;
  logic btn_q;
  logic rst_busy;
  logic group_good;

  // the sequence order lives in the rail power-good chain; enables go out together
  assign group_good = &main_power_good;

  always_ff @(posedge mclk) begin
    if (srst) begin
      keep_alive_rail_en <= 1'b0;
    end else begin
      keep_alive_rail_en <= ctl.uvlo_ok;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      press_cnt <= 64'h0;
      long_seen <= 1'b0;
      btn_q <= 1'b0;
      short_pulse <= 1'b0;
    end else begin
      btn_q <= ctl.push_button_pressed;
      short_pulse <= 1'b0;
      if (ctl.push_button_pressed) begin
        if (press_cnt < LONG_CYC) begin
          press_cnt <= press_cnt + 64'h1;
        end else begin
          long_seen <= 1'b1;
        end
      end else begin
        if (btn_q && !long_seen) begin
          short_pulse <= 1'b1;
        end
        press_cnt <= 64'h0;
        long_seen <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      state <= PPS_OFF;
    end else begin
      case (state)
        PPS_OFF: begin
          if (ctl.wake_trigger_pin && ctl.uvlo_ok) begin
            state <= PPS_WAKE;
          end
        end
        PPS_WAKE: begin
          if (long_seen) begin
            state <= PPS_LONG_OFF;
          end else if (ctl.power_hold_input && main_power_good[IDX_RAIL_SEVEN]) begin
            state <= PPS_HELD;
          end else if (!ctl.wake_trigger_pin) begin
            state <= PPS_OFF;
          end
        end
        PPS_HELD: begin
          if (long_seen) begin
            state <= PPS_LONG_OFF;
          end else if (!ctl.power_hold_input && !ctl.wake_trigger_pin) begin
            state <= PPS_OFF;
          end
        end
        PPS_LONG_OFF: begin
          if (!ctl.push_button_pressed) begin
            state <= PPS_WAKE;
          end
        end
        default: state <= PPS_OFF;
      endcase
    end
  end

  // all main rails off in long-press state
  always_ff @(posedge mclk) begin
    if (srst) begin
      main_rail_en <= MAIN_ALL_OFF;
    end else if (state == PPS_WAKE || state == PPS_HELD) begin
      main_rail_en <= MAIN_ALL_ON;
    end else begin
      main_rail_en <= MAIN_ALL_OFF;
    end
  end

  // rail three gate; either low drops it
  always_ff @(posedge mclk) begin
    if (srst) begin
      rail_three_en <= 1'b0;
    end else begin
      rail_three_en <= ctl.power_hold_input && ctl.rail_three_enable_input &&
                       state != PPS_LONG_OFF;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      rail_two_vsel_high <= 1'b0;
    end else begin
      rail_two_vsel_high <= ctl.rail_two_voltage_select;
    end
  end

  // delayed reset release; counted in clocks
  always_ff @(posedge mclk) begin
    if (srst) begin
      rst_cnt <= 64'h0;
      rst_busy <= 1'b1;
      processor_reset_output_n <= 1'b0;
    end else if (!main_power_good[IDX_RAIL_TWELVE] || short_pulse) begin
      rst_cnt <= 64'h0;
      rst_busy <= 1'b1;
      processor_reset_output_n <= 1'b0;
    end else if (rst_busy) begin
      processor_reset_output_n <= 1'b0;
      if (rst_cnt >= RST_CYC - 64'h1) begin
        rst_busy <= 1'b0;
      end else begin
        rst_cnt <= rst_cnt + 64'h1;
      end
    end else begin
      processor_reset_output_n <= 1'b1;
    end
  end

  // open drain: data always low, only enable moves
  always_ff @(posedge mclk) begin
    if (srst) begin
      interrupt_request_output_out <= 1'b0;
      interrupt_request_output_oe <= 1'b0;
    end else begin
      interrupt_request_output_out <= 1'b0;
      interrupt_request_output_oe <= ctl.irq_event;
    end
  end

  // check-only state: cycles rail twelve has stood good, saturating
  logic [63:0] good12_cnt;

  // delay reference for the reset checks
  always_ff @(posedge mclk) begin
    if (srst) begin
      good12_cnt <= 64'h0;
    end else if (!main_power_good[IDX_RAIL_TWELVE]) begin
      good12_cnt <= 64'h0;
    end else if (good12_cnt < RST_CYC) begin
      good12_cnt <= good12_cnt + 64'h1;
    end
  end

  // multi-step behaviours: state moves first, the enables one edge later
  sequence s_wake_seen;
    state == PPS_OFF && ctl.wake_trigger_pin && ctl.uvlo_ok;
  endsequence
  sequence s_group_up;
    ##2 (main_rail_en == MAIN_ALL_ON);
  endsequence
  sequence s_long_hit;
    long_seen && state == PPS_HELD;
  endsequence
  sequence s_all_down;
    ##2 (main_rail_en == MAIN_ALL_OFF && !rail_three_en);
  endsequence
  sequence s_hold_lost;
    state == PPS_HELD && !long_seen && !ctl.power_hold_input && !ctl.wake_trigger_pin;
  endsequence
  sequence s_group_down;
    ##2 (main_rail_en == MAIN_ALL_OFF);
  endsequence

  // pin-level checks
  chk_od_low: assert property (@(posedge mclk) disable iff (srst)
    interrupt_request_output_out == 1'b0)
    else $error("irq driven high");
  chk_irq_pull: assert property (@(posedge mclk) disable iff (srst)
    ctl.irq_event |=> interrupt_request_output_oe)
    else $error("irq not pulled low");
  chk_irq_free: assert property (@(posedge mclk) disable iff (srst)
    !ctl.irq_event |=> !interrupt_request_output_oe)
    else $error("irq pulled without event");
  chk_r3_and: assert property (@(posedge mclk) disable iff (srst)
    rail_three_en |-> $past(ctl.power_hold_input && ctl.rail_three_enable_input))
    else $error("rail three without both enables");
  chk_r3_drop: assert property (@(posedge mclk) disable iff (srst)
    !ctl.rail_three_enable_input |=> !rail_three_en)
    else $error("rail three stayed");
  chk_r3_hold_drop: assert property (@(posedge mclk) disable iff (srst)
    !ctl.power_hold_input |=> !rail_three_en)
    else $error("rail three kept without hold");
  chk_keep_alive: assert property (@(posedge mclk) disable iff (srst)
    ctl.uvlo_ok |=> keep_alive_rail_en)
    else $error("keep-alive not on");
  chk_ka_off: assert property (@(posedge mclk) disable iff (srst)
    !ctl.uvlo_ok |=> !keep_alive_rail_en)
    else $error("keep-alive on under lockout");
  chk_vsel: assert property (@(posedge mclk) disable iff (srst)
    ##1 rail_two_vsel_high == $past(ctl.rail_two_voltage_select))
    else $error("rail two select wrong");

  // group state checks
  chk_wake_start: assert property (@(posedge mclk) disable iff (srst)
    s_wake_seen |-> s_group_up)
    else $error("group not started");
  chk_uvlo_block: assert property (@(posedge mclk) disable iff (srst)
    (state == PPS_OFF && !ctl.uvlo_ok) |=> state == PPS_OFF)
    else $error("group started under lockout");
  chk_wake_drop: assert property (@(posedge mclk) disable iff (srst)
    (state == PPS_WAKE && !long_seen && !ctl.wake_trigger_pin &&
     !(ctl.power_hold_input && main_power_good[IDX_RAIL_SEVEN])) |=> state == PPS_OFF)
    else $error("group kept without wake or hold");
  chk_held_entry: assert property (@(posedge mclk) disable iff (srst)
    (state == PPS_WAKE && !long_seen && ctl.power_hold_input &&
     main_power_good[IDX_RAIL_SEVEN]) |=> state == PPS_HELD)
    else $error("group not latched by hold");
  chk_hold_latch: assert property (@(posedge mclk) disable iff (srst)
    (state == PPS_HELD && ctl.power_hold_input && !long_seen) |=> state == PPS_HELD)
    else $error("group dropped while held");
  chk_held_on: assert property (@(posedge mclk) disable iff (srst)
    state == PPS_HELD |=> main_rail_en == MAIN_ALL_ON)
    else $error("group off while latched");
  chk_hold_off: assert property (@(posedge mclk) disable iff (srst)
    s_hold_lost |-> s_group_down)
    else $error("no shutdown on hold low");
  chk_long_off: assert property (@(posedge mclk) disable iff (srst)
    s_long_hit |-> s_all_down)
    else $error("long press did not power down");
  chk_long_rails: assert property (@(posedge mclk) disable iff (srst)
    state == PPS_LONG_OFF |=> (main_rail_en == MAIN_ALL_OFF && !rail_three_en))
    else $error("rail on during long-press off");
  chk_restart: assert property (@(posedge mclk) disable iff (srst)
    (state == PPS_LONG_OFF && !ctl.push_button_pressed) |=> state == PPS_WAKE)
    else $error("no restart after long press");

  // button and reset checks
  chk_long_len: assert property (@(posedge mclk) disable iff (srst)
    $rose(long_seen) |-> $past(press_cnt) == LONG_CYC)
    else $error("long press before threshold");
  chk_short_len: assert property (@(posedge mclk) disable iff (srst)
    short_pulse |-> !$past(long_seen))
    else $error("short press after threshold");
  chk_short_rst: assert property (@(posedge mclk) disable iff (srst)
    short_pulse |=> !processor_reset_output_n)
    else $error("short press no reset");
  chk_rst_gate: assert property (@(posedge mclk) disable iff (srst)
    !main_power_good[IDX_RAIL_TWELVE] |=> !processor_reset_output_n)
    else $error("reset released without rail twelve");
  chk_rst_busy: assert property (@(posedge mclk) disable iff (srst)
    rst_busy |=> !processor_reset_output_n)
    else $error("reset released while counting");
  chk_rst_delay: assert property (@(posedge mclk) disable iff (srst)
    $rose(processor_reset_output_n) |-> good12_cnt >= RST_CYC)
    else $error("reset released too early");
endmodule // pps_sequencer

// file: pps_rail_model.sv
// partner model: rail power-good returns and the hold strap
`timescale 1ns/1ps
module pps_rail_model
  import pps_pkg::*;
(
  input wire logic mclk,
  input wire logic slow,
  input wire logic hold_allow,
  input wire logic [NUM_MAIN-1:0] main_rail_en,
  output logic [NUM_MAIN-1:0] main_power_good,
  output logic power_hold_input
);
  logic [NUM_MAIN-1:0] d1;
  logic [NUM_MAIN-1:0] d2;
  // per-rail good
  // good drops one cycle after the enable, rises two or three cycles late
  always_ff @(posedge mclk) begin
    d1 <= main_rail_en;
    d2 <= d1;
    main_power_good <= main_rail_en & (slow ? d2 : d1);
  end
  assign power_hold_input = hold_allow & main_power_good[IDX_RAIL_SEVEN];
endmodule // pps_rail_model

// file: pps_sequencer_test.sv
// self-checking bench for the power sequencer
`timescale 1ns/1ps
module pps_sequencer_test
  import pps_pkg::*;
;
  localparam int LC = 20;
  localparam int RC = 10;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic slow = 1'b0;
  logic hold_allow = 1'b1;
  logic sample = 1'b0;
  logic hold;
  pps_ctl_t drv = '0;
  pps_ctl_t ctl;
  logic [NUM_MAIN-1:0] pg;
  logic [NUM_MAIN-1:0] men;
  logic ka, r3, vsel, rstn, irq_o, irq_oe;
  int num_errors = 0;
  int checks_done = 0;
  logic [15:0] notes[$];
  always #2.5 mclk = ~mclk;
  always_comb begin
    ctl = drv;
    ctl.power_hold_input = hold;
  end
  pps_sequencer #(.LONG_CYC(LC), .RST_CYC(RC)) uut (.mclk(mclk), .srst(srst), .ctl(ctl),
    .main_power_good(pg), .keep_alive_rail_en(ka), .main_rail_en(men), .rail_three_en(r3),
    .rail_two_vsel_high(vsel), .processor_reset_output_n(rstn),
    .interrupt_request_output_out(irq_o), .interrupt_request_output_oe(irq_oe));
  pps_rail_model partner (.mclk(mclk), .slow(slow), .hold_allow(hold_allow),
    .main_rail_en(men), .main_power_good(pg), .power_hold_input(hold));
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    checks_done++;
    if (seen !== want) begin
      num_errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  // note a snapshot; the monitor takes it at the falling edge
  task automatic expect_out(input logic m, input logic r, input logic n);
    notes.push_back({drv.uvlo_ok, {NUM_MAIN{m}}, r, drv.rail_two_voltage_select, n,
      drv.irq_event, 1'b0});
    sample = 1'b1;
    @(negedge mclk);
    @(posedge mclk);
    #1 sample = 1'b0;
  endtask
  always @(negedge mclk) begin
    if (sample) begin
      check({ka, men, r3, vsel, rstn, irq_oe, irq_o}, notes.pop_front());
    end
  end
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // whole run is a few hundred cycles; this leaves ample slack
  initial begin
    #(5 * 3000);
    num_errors++;
    report_and_stop();
  end
  initial begin
    void'($urandom(42171));
    step(20);
    srst = 1'b0;
    step(1);
    drv.uvlo_ok = 1'b1;
    step(3);
    expect_out(1'b0, 1'b0, 1'b0);
    drv.wake_trigger_pin = 1'b1;
    step(RC + 12);
    expect_out(1'b1, 1'b0, 1'b1);
    drv.wake_trigger_pin = 1'b0;
    step(6);
    expect_out(1'b1, 1'b0, 1'b1);
    $display("startup test done");
    for (int i = 0; i < 16; i++) begin
      {drv.rail_three_enable_input, drv.rail_two_voltage_select, drv.irq_event} = 3'($urandom);
      step(2);
      expect_out(1'b1, drv.rail_three_enable_input, 1'b1);
    end
    $display("pin follow test done");
    drv.push_button_pressed = 1'b1;
    step(5);
    drv.push_button_pressed = 1'b0;
    step(3);
    expect_out(1'b1, drv.rail_three_enable_input, 1'b0);
    step(RC + 4);
    expect_out(1'b1, drv.rail_three_enable_input, 1'b1);
    $display("short press test done");
    drv.rail_three_enable_input = 1'b0;
    hold_allow = 1'b0;
    step(4);
    expect_out(1'b0, 1'b0, 1'b0);
    hold_allow = 1'b1;
    slow = 1'b1;
    drv.wake_trigger_pin = 1'b1;
    step(RC + 14);
    expect_out(1'b1, 1'b0, 1'b1);
    // host enables rail three only once the group is good
    drv.rail_three_enable_input = 1'b1;
    step(2);
    expect_out(1'b1, 1'b1, 1'b1);
    $display("hold release test done");
    drv.push_button_pressed = 1'b1;
    step(LC + 6);
    expect_out(1'b0, 1'b0, 1'b0);
    drv.push_button_pressed = 1'b0;
    step(RC + 14);
    expect_out(1'b1, 1'b1, 1'b1);
    $display("long press test done");
    report_and_stop();
  end
endmodule // pps_sequencer_test
